// ### hw/reload_pwm_timer.sv
// auto-reload pwm timer with capture inputs behind an avalon-mm slave
//
// Functional notes
// [R1] pwm frequency is counter rate over 256-reload
// [R2] output enable bit drives the channel pin
// [R3] overflow drives pins to polarity-selected level
// [R4] compare match returns pin to opposite level
// [R5] software keeps compare above reload for waveform
// [R6] duty resolution one step in 256-reload
// [R7] pwm generation stops while halted
// [R8] overflow sets flag, gated interrupt request
// [R9] external events counted until overflow flag
// [R10] software stops counter before halt on external clock
// [R11] selected capture edge latches counter, sets flag
// [R12] per channel edge select and interrupt enable
// [R13] capture blocked until value read; read clears flag
// [R14] capture interrupt follows flag and enable
// [R15] halt stops capture loads, keeps interrupt flags
// [R16] capture input passes two clock flip-flops
// [R17] unprescaled capture holds counter after event
// [R18] enabled capture edge in halt raises wake
// [R19] clock select picks cpu or external input
// [R20] prescale code divides by two to the code
// [R21] run enable low freezes counter and prescaler
// [R22] force reload write-only, loads reload, clears prescaler
// [R23] overflow flag at ff to reload, cleared by read
// [R24] counter reloads on overflow, prescaler untouched
// [R25] compare copied from duty register at overflow
// [R26] polarity change inverts output at once
// [R27] single bus access, read effects only on reads
module reload_pwm_timer
  import reload_pwm_timer_pkg::*;
#(
  parameter int NUM_PWM = 4,
  parameter int NUM_CAP = 2
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [BUS_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [BUS_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic halt_i,
  input wire logic ext_clock_pin_i,
  input wire logic [NUM_CAP-1:0] capture_input_pin_i,
  output logic [NUM_PWM-1:0] pulse_out_pin_o,
  output logic [NUM_PWM-1:0] pulse_out_pin_oe_o,
  output logic overflow_irq_o,
  output logic [NUM_CAP-1:0] capture_irq_o,
  output logic wake_o
);

  if (NUM_PWM < 1 || NUM_PWM > 4 || NUM_CAP < 1 || NUM_CAP > 2) begin : g_chk
    $error("reload_pwm_timer: 1..4 pwm and 1..2 capture channels only");
  end

  timer_ctrl_type ctrl_reg;
  logic overflow_flag_reg;
  logic [REG_W-1:0] reload_value_reg;
  logic [REG_W-1:0] counter_reg;
  logic [6:0] presc_reg;
  logic [REG_W-1:0] duty_cycle_reg [NUM_PWM];
  logic [REG_W-1:0] channel_compare_value [NUM_PWM];
  logic [NUM_PWM-1:0] channel_out_enable;
  logic [NUM_PWM-1:0] channel_polarity;
  logic [NUM_PWM-1:0] phase_reg;
  logic [NUM_CAP-1:0] capture_edge_select;
  logic [NUM_CAP-1:0] capture_irq_enable;
  logic [NUM_CAP-1:0] capture_flag;
  logic [NUM_CAP-1:0] cf_seen_reg;
  logic [REG_W-1:0] capture_value_reg [NUM_CAP];
  logic [NUM_CAP-1:0] cap_s1_reg, cap_s2_reg, cap_s3_reg;
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic [BUS_W-1:0] readdata_reg;
  logic waitrequest_reg;

  logic req, accept, wr_lane, sample;
  logic [7:0] idx;
  logic input_tick, run, presc_step, count_tick, overflow;
  logic wr_csr, wr_counter, force_reload;
  logic [NUM_CAP-1:0] capture_event, cap_clear, cap_load;
  logic [REG_W-1:0] rd_mux;

  // bus decode: one wait cycle, then the access completes
  assign req = avs_read_i | avs_write_i;
  assign sample = req & waitrequest_reg;
  assign accept = req & ~waitrequest_reg; // R27
  assign idx = word_index(avs_address_i);
  assign wr_lane = accept & avs_write_i & avs_byteenable_i[0];
  assign wr_csr = wr_lane & (idx == IDX_CSR);
  assign wr_counter = wr_lane & (idx == IDX_COUNTER);
  assign force_reload = wr_csr & avs_writedata_i[CSR_FRL]; // R22

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= ~sample; // R27
    end
  end

  // read multiplexer; unmapped words read as zero
  always_comb begin
    rd_mux = REG_RESET;
    unique case (idx)
      IDX_PWM_CTRL: begin
        rd_mux = 8'(channel_out_enable) << PWM_OE_LO;
        rd_mux = rd_mux | 8'(channel_polarity);
      end
      IDX_CSR: begin
        rd_mux = {ctrl_reg.external_clock_select, ctrl_reg.prescale_select,
                  ctrl_reg.counter_run_enable, 1'b0, // R22
                  ctrl_reg.overflow_irq_enable, overflow_flag_reg};
      end
      IDX_COUNTER: rd_mux = counter_reg;
      IDX_RELOAD: rd_mux = reload_value_reg;
      IDX_CAP_CTRL: begin
        rd_mux = (8'(capture_edge_select) << CAP_CS_LO) |
                 (8'(capture_irq_enable) << CAP_CIE_LO) | 8'(capture_flag);
      end
      default: begin
        for (int c = 0; c < NUM_PWM; c++) begin
          if (idx == 8'(IDX_DUTY0 - 8'(c))) rd_mux = duty_cycle_reg[c];
        end
        for (int c = 0; c < NUM_CAP; c++) begin
          if (idx == 8'(IDX_CAP_VAL1 + 8'(c))) rd_mux = capture_value_reg[c];
        end
      end
    endcase
  end

  // read data is sampled in the wait cycle and stands while wait is low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      readdata_reg <= '0;
      cf_seen_reg <= '0;
    end else if (sample) begin
      readdata_reg <= avs_read_i ? {24'h000000, rd_mux} : '0;
      cf_seen_reg <= capture_flag; // only flags software saw get cleared
    end
  end

  // software-owned configuration registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_reg <= CTRL_RESET;
      reload_value_reg <= REG_RESET;
      channel_out_enable <= '0;
      channel_polarity <= '0;
      capture_edge_select <= '0;
      capture_irq_enable <= '0;
      for (int c = 0; c < NUM_PWM; c++) duty_cycle_reg[c] <= REG_RESET;
    end else if (wr_lane) begin
      if (wr_csr) begin
        ctrl_reg.external_clock_select <= avs_writedata_i[CSR_EXT]; // R19
        ctrl_reg.prescale_select <= avs_writedata_i[CSR_PS_LO +: 3]; // R20
        ctrl_reg.counter_run_enable <= avs_writedata_i[CSR_RUN];
        ctrl_reg.overflow_irq_enable <= avs_writedata_i[CSR_OIE];
      end
      if (idx == IDX_RELOAD) reload_value_reg <= avs_writedata_i[7:0];
      if (idx == IDX_PWM_CTRL) begin
        channel_out_enable <= avs_writedata_i[PWM_OE_LO +: NUM_PWM]; // R2
        channel_polarity <= avs_writedata_i[NUM_PWM-1:0];
      end
      if (idx == IDX_CAP_CTRL) begin
        capture_edge_select <= avs_writedata_i[CAP_CS_LO +: NUM_CAP]; // R12
        capture_irq_enable <= avs_writedata_i[CAP_CIE_LO +: NUM_CAP]; // R12
      end
      for (int c = 0; c < NUM_PWM; c++) begin
        if (idx == 8'(IDX_DUTY0 - 8'(c))) begin
          duty_cycle_reg[c] <= avs_writedata_i[7:0];
        end
      end
    end
  end

  // external clock and capture pins pass two flip-flops, then an edge stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
      cap_s1_reg <= '0;
      cap_s2_reg <= '0;
      cap_s3_reg <= '0;
    end else begin
      ext_s1_reg <= ext_clock_pin_i;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      cap_s1_reg <= capture_input_pin_i; // R16
      cap_s2_reg <= cap_s1_reg; // R16
      cap_s3_reg <= cap_s2_reg;
    end
  end

  // counting enables: input select, run gate, prescaler tap
  assign input_tick = ctrl_reg.external_clock_select ?
                      (ext_s2_reg & ~ext_s3_reg) : 1'b1; // R19 R9
  assign run = ctrl_reg.counter_run_enable & ~halt_i; // R21 R7
  assign presc_step = run & input_tick;
  assign count_tick = presc_step & ((presc_reg &
                      tap_mask(ctrl_reg.prescale_select)) ==
                      tap_mask(ctrl_reg.prescale_select)); // R20
  assign overflow = count_tick & (counter_reg == COUNT_TOP); // R23

  // prescaler and counter; direct loads clear the prescaler
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      presc_reg <= PRESC_RESET;
      counter_reg <= REG_RESET;
    end else if (force_reload) begin
      presc_reg <= PRESC_RESET; // R22
      counter_reg <= reload_value_reg; // R22
    end else if (wr_counter) begin
      presc_reg <= PRESC_RESET;
      counter_reg <= avs_writedata_i[7:0];
    end else begin
      if (presc_step) presc_reg <= 7'(presc_reg + 7'h01); // R21
      if (overflow) begin
        counter_reg <= reload_value_reg; // R24 R1 R9
      end else if (count_tick) begin
        counter_reg <= 8'(counter_reg + 8'h01);
      end
    end
  end

  // overflow flag: set wins over the read that clears it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      overflow_flag_reg <= 1'b0;
    end else if (overflow) begin
      overflow_flag_reg <= 1'b1; // R8
    end else if (accept & avs_read_i & (idx == IDX_CSR)
                 & readdata_reg[CSR_OVF]) begin
      overflow_flag_reg <= 1'b0; // R23 R27
    end
  end

  // compare reload and pwm phase per channel
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase_reg <= '0;
      for (int c = 0; c < NUM_PWM; c++) begin
        channel_compare_value[c] <= REG_RESET;
      end
    end else begin
      for (int c = 0; c < NUM_PWM; c++) begin
        if (overflow) begin
          channel_compare_value[c] <= duty_cycle_reg[c]; // R25
          phase_reg[c] <= 1'b1; // R3 R6
        end else if (count_tick &
                     (counter_reg == channel_compare_value[c])) begin
          phase_reg[c] <= 1'b0; // R4 R5
        end
      end
    end
  end

  // pins follow phase and polarity every cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pulse_out_pin_o <= '0;
      pulse_out_pin_oe_o <= '0;
    end else begin
      pulse_out_pin_o <= phase_reg ^ channel_polarity; // R3 R26
      pulse_out_pin_oe_o <= channel_out_enable; // R2
    end
  end

  // capture edges, clears and loads
  always_comb begin
    for (int c = 0; c < NUM_CAP; c++) begin
      capture_event[c] = capture_edge_select[c] ?
                         (cap_s2_reg[c] & ~cap_s3_reg[c]) :
                         (~cap_s2_reg[c] & cap_s3_reg[c]); // R11 R12
      cap_clear[c] = accept & avs_read_i & cf_seen_reg[c] &
                     (idx == 8'(IDX_CAP_VAL1 + 8'(c))); // R13 R27
      cap_load[c] = capture_event[c] & ~halt_i &
                    (~capture_flag[c] | cap_clear[c]); // R13 R15
    end
  end

  // capture registers hold the counter seen at the synchronised edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      capture_flag <= '0;
      for (int c = 0; c < NUM_CAP; c++) capture_value_reg[c] <= REG_RESET;
    end else begin
      for (int c = 0; c < NUM_CAP; c++) begin
        if (cap_load[c]) capture_value_reg[c] <= counter_reg; // R11 R17
        if (capture_event[c]) begin
          capture_flag[c] <= 1'b1; // R11 R15
        end else if (cap_clear[c]) begin
          capture_flag[c] <= 1'b0; // R13
        end
      end
    end
  end

  // interrupt levels and halt wake-up
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      overflow_irq_o <= 1'b0;
      capture_irq_o <= '0;
      wake_o <= 1'b0;
    end else begin
      overflow_irq_o <= overflow_flag_reg & ctrl_reg.overflow_irq_enable; // R8
      capture_irq_o <= capture_flag & capture_irq_enable; // R14
      wake_o <= halt_i & |(capture_event & capture_irq_enable); // R18
    end
  end

  assign avs_readdata_o = readdata_reg;
  assign avs_waitrequest_o = waitrequest_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_top_tick;
    overflow & ~force_reload & ~wr_counter;
  endsequence

  sequence s_cap_edge0;
    capture_event[0] & ~halt_i & ~capture_flag[0];
  endsequence

  AST_OVF_RELOAD: assert property (s_top_tick |=> // R24
    counter_reg == $past(reload_value_reg)
    && presc_reg == 7'($past(presc_reg) + 7'h01))
    else $error("counter did not reload on overflow");

  AST_OVF_FLAG: assert property (s_top_tick |=> overflow_flag_reg) // R8
    else $error("overflow flag not set");

  AST_OVF_IRQ: assert property (overflow_flag_reg & // R8
    ctrl_reg.overflow_irq_enable |=> overflow_irq_o)
    else $error("overflow interrupt missing");

  AST_RUN_HOLD: assert property (~run & ~force_reload & ~wr_counter // R21
    |=> $stable(counter_reg) && $stable(presc_reg))
    else $error("stopped counter moved");

  AST_FORCE: assert property (force_reload |=> // R22
    counter_reg == $past(reload_value_reg) && presc_reg == PRESC_RESET)
    else $error("force reload failed");

  AST_CAP_LOAD: assert property (s_cap_edge0 |=> // R11
    capture_flag[0] && capture_value_reg[0] == $past(counter_reg))
    else $error("capture did not latch counter");

  AST_CAP_BLOCK: assert property (capture_flag[0] & ~cap_clear[0] // R13
    |=> $stable(capture_value_reg[0]))
    else $error("capture register overwritten");

  AST_HALT_CAP: assert property (halt_i // R15
    |=> $stable(capture_value_reg[0]))
    else $error("capture loaded in halt");

  AST_PWM_CMP: assert property (count_tick & ~overflow & // R4
    (counter_reg == channel_compare_value[0]) |=> ~phase_reg[0] ##1
    pulse_out_pin_o[0] == channel_polarity[0] || $changed(channel_polarity[0]))
    else $error("compare match did not end the pulse");

  AST_POLARITY: assert property ($changed(channel_polarity[0]) & // R26
    $stable(phase_reg[0]) |=> pulse_out_pin_o[0] != $past(pulse_out_pin_o[0]))
    else $error("polarity change not seen on pin");

  AST_BUS_ONE: assert property (sample |=> ~avs_waitrequest_o ##1 // R27
    avs_waitrequest_o)
    else $error("bus answer not one cycle");

endmodule // reload_pwm_timer

// ### hw/reload_pwm_timer_pkg.sv
// constants, field layout and carrier types of the reload pwm timer
package reload_pwm_timer_pkg;
  localparam int ADDR_W = 10;
  localparam int BUS_W = 32;
  localparam int REG_W = 8;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DUTY0 = 8'h34;
  localparam logic [7:0] IDX_PWM_CTRL = 8'h35;
  localparam logic [7:0] IDX_CSR = 8'h36;
  localparam logic [7:0] IDX_COUNTER = 8'h37;
  localparam logic [7:0] IDX_RELOAD = 8'h38;
  localparam logic [7:0] IDX_CAP_CTRL = 8'h39;
  localparam logic [7:0] IDX_CAP_VAL1 = 8'h3a;
  // timer_control_status fields
  localparam int CSR_EXT = 7;
  localparam int CSR_PS_LO = 4;
  localparam int CSR_RUN = 3;
  localparam int CSR_FRL = 2;
  localparam int CSR_OIE = 1;
  localparam int CSR_OVF = 0;
  // pwm_output_control and capture_control_status fields
  localparam int PWM_OE_LO = 4;
  localparam int CAP_CS_LO = 4;
  localparam int CAP_CIE_LO = 2;
  // values after reset and counter limits
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] PRESC_RESET = 7'h00;
  localparam logic [7:0] COUNT_TOP = 8'hff;
  localparam logic [1:0] WORD_SHIFT = 2'h2;

  typedef struct packed {
    logic external_clock_select;
    logic [2:0] prescale_select;
    logic counter_run_enable;
    logic overflow_irq_enable;
  } timer_ctrl_type;

  localparam timer_ctrl_type CTRL_RESET = '0;

  // tap mask of the prescaler for a divide by two to the code
  function automatic logic [6:0] tap_mask(input logic [2:0] code);
    tap_mask = 7'(({7'h00, 1'b1} << code) - 8'h01);
  endfunction

  // word index of a byte address
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[ADDR_W-1:WORD_SHIFT];
  endfunction
endpackage

// ### sim/pin_partner.sv
// far-side pin model: event clock source and capture pin drivers
module pin_partner (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pulse_req_i,
  input wire logic [1:0] cap_level_i,
  output logic ext_clock_pin_o,
  output logic [1:0] capture_input_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] step_reg;
  // one event per request: pin high three cycles, then low three
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      step_reg <= 3'h0;
    end else if (pulse_req_i) begin
      step_reg <= 3'h6;
    end else if (step_reg != 3'h0) begin
      step_reg <= step_reg - 3'h1;
    end
  end
  assign ext_clock_pin_o = (step_reg > 3'h3);
  // capture pins are always driven, so never left floating
  assign capture_input_pin_o = cap_level_i;
endmodule // pin_partner

// ### sim/test_reload_pwm_timer.sv
// self-checking bench of the reload pwm timer
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_mismatch++; $display("wrong value at %0t: %h vs %h", $time, a, b); \
  end end
module test_reload_pwm_timer
  import reload_pwm_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [BUS_W-1:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [BUS_W-1:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic halt_i = 1'b0;
  logic ext_clock_pin_i;
  logic [1:0] capture_input_pin_i;
  logic [3:0] pulse_out_pin_o;
  logic [3:0] pulse_out_pin_oe_o;
  logic overflow_irq_o;
  logic [1:0] capture_irq_o;
  logic wake_o;
  logic pulse_req = 1'b0;
  logic [1:0] cap_lv = 2'h0;
  logic [32:0] exp_q[$];
  logic [32:0] exp_w;
  logic [31:0] seed = 32'h685e;
  logic [7:0] v;
  int n_mismatch = 0;
  int samples_checked = 0;
  int hi, per, flips;

  reload_pwm_timer dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .halt_i(halt_i), .ext_clock_pin_i(ext_clock_pin_i),
    .capture_input_pin_i(capture_input_pin_i),
    .pulse_out_pin_o(pulse_out_pin_o),
    .pulse_out_pin_oe_o(pulse_out_pin_oe_o),
    .overflow_irq_o(overflow_irq_o), .capture_irq_o(capture_irq_o),
    .wake_o(wake_o));
  pin_partner partner_u (
    .clk_i(clk_i), .reset_i(reset_i), .pulse_req_i(pulse_req),
    .cap_level_i(cap_lv), .ext_clock_pin_o(ext_clock_pin_i),
    .capture_input_pin_o(capture_input_pin_i));

  // free-running 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // watched level selected by number
  function automatic logic sig(input int s);
    case (s)
      0: sig = overflow_irq_o;
      1: sig = capture_irq_o[0];
      2: sig = capture_irq_o[1];
      3: sig = wake_o;
      4: sig = pulse_out_pin_o[0];
      default: sig = ~pulse_out_pin_o[0];
    endcase
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // bounded wait for a level sampled on the rising edge
  task automatic wait_hi(input int s);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 5000) begin
        n_mismatch++;
        print_verdict();
      end
    end while (sig(s) !== 1'b1);
  endtask

  // one avalon access; op 0 write, 1 checked read, 2 unchecked read
  task automatic bus(input logic [7:0] idx, input int op,
      input logic [7:0] d);
    int n;
    n = 0;
    avs_address_i <= {idx, 2'h0};
    avs_read_i <= (op != 0);
    avs_write_i <= (op == 0);
    avs_writedata_i <= {24'h0, d};
    if (op != 0) exp_q.push_back({op == 2, 24'h0, d});
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) begin
        n_mismatch++;
        print_verdict();
      end
    end while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // one external event pulse, then let it pass the synchroniser
  task automatic ev();
    pulse_req <= 1'b1;
    @(posedge clk_i);
    pulse_req <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask

  // high time and period of channel 0, from one rising edge to the next
  task automatic measure(output int h, output int p);
    wait_hi(5);
    wait_hi(4);
    h = 0;
    p = 0;
    do begin
      if (pulse_out_pin_o[0] === 1'b1) h++;
      p++;
      @(posedge clk_i);
    end while ((pulse_out_pin_o[0] !== 1'b1 || h == p) && p < 5000);
  endtask

  // read results are compared against the oldest note
  always @(posedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      exp_w = exp_q.pop_front();
      if (!exp_w[32]) `CHK(avs_readdata_o, exp_w[31:0])
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 8'h31; i <= 8'h3b; i++) bus(8'(i), 1, 8'h00);
    bus(8'h10, 1, 8'h00);
    for (int c = 1; c <= 3; c++) begin
      seed = lfsr(seed);
      v = seed[7:0];
      bus(8'h34 - 8'(c), 0, v);
      bus(8'h34 - 8'(c), 1, v);
    end
    avs_byteenable_i <= 4'h0;
    bus(8'h31, 0, ~v);
    avs_byteenable_i <= 4'hf;
    bus(8'h31, 1, v);
    $display("test registers done");
    // channels 1..3 get a compare below reload: no waveform, pins stay 1
    for (int c = 1; c <= 3; c++) bus(8'h34 - 8'(c), 0, 8'h00);
    bus(8'h38, 0, 8'hf0);
    bus(8'h34, 0, 8'hf8);
    bus(8'h35, 0, 8'h10);
    bus(8'h36, 0, 8'h0c);
    bus(8'h36, 1, 8'h08);
    `CHK(pulse_out_pin_oe_o, 4'h1)
    measure(hi, per);
    `CHK(per, 16)
    `CHK(hi, 9)
    bus(8'h36, 0, 8'h0a);
    wait_hi(0);
    bus(8'h36, 1, 8'h0b);
    bus(8'h36, 1, 8'h0a);
    `CHK(overflow_irq_o, 1'b0)
    bus(8'h36, 0, 8'h2c);
    measure(hi, per);
    `CHK(per, 64)
    `CHK(hi, 36)
    bus(8'h35, 0, 8'h11);
    measure(hi, per);
    `CHK(per, 64)
    `CHK(hi, 28)
    halt_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    flips = 0;
    v[0] = pulse_out_pin_o[0];
    repeat (80) begin
      @(posedge clk_i);
      if (pulse_out_pin_o[0] !== v[0]) flips++;
    end
    `CHK(flips, 0)
    `CHK(pulse_out_pin_o[3:1], 3'h7)
    halt_i <= 1'b0;
    // top prescaler tap: divide by 128, inverted polarity still set
    bus(8'h36, 0, 8'h7c);
    measure(hi, per);
    `CHK(per, 2048)
    `CHK(hi, 896)
    $display("test pwm done");
    bus(8'h36, 0, 8'h00);
    bus(8'h37, 0, 8'h55);
    bus(8'h39, 0, 8'h14);
    bus(8'h37, 1, 8'h55);
    cap_lv <= 2'h1;
    wait_hi(1);
    bus(8'h37, 0, 8'h66);
    cap_lv <= 2'h0;
    repeat (6) @(posedge clk_i);
    cap_lv <= 2'h1;
    repeat (6) @(posedge clk_i);
    bus(8'h3a, 1, 8'h55);
    bus(8'h39, 1, 8'h14);
    `CHK(capture_irq_o[0], 1'b0)
    halt_i <= 1'b1;
    cap_lv <= 2'h0;
    repeat (6) @(posedge clk_i);
    cap_lv <= 2'h1;
    wait_hi(3);
    bus(8'h39, 1, 8'h15);
    bus(8'h3a, 1, 8'h55);
    halt_i <= 1'b0;
    bus(8'h39, 0, 8'h08);
    cap_lv <= 2'h3;
    repeat (8) @(posedge clk_i);
    `CHK(capture_irq_o[1], 1'b0)
    cap_lv <= 2'h1;
    wait_hi(2);
    bus(8'h3b, 1, 8'h66);
    $display("test capture done");
    bus(8'h38, 0, 8'hfd);
    bus(8'h36, 0, 8'h8e);
    bus(8'h36, 2, 8'h00);
    ev();
    ev();
    `CHK(overflow_irq_o, 1'b0)
    ev();
    `CHK(overflow_irq_o, 1'b1)
    bus(8'h36, 0, 8'h82);
    $display("test events done");
    print_verdict();
  end
endmodule // test_reload_pwm_timer
